/* capture_window_scale_regs.vh */
// register offsets, field positions, reset values and timing for the capture window / scale register bank
// assumes a byte-wide register port with 8-bit addresses from the serial control slave
`ifndef CAPTURE_WINDOW_SCALE_REGS_VH
`define CAPTURE_WINDOW_SCALE_REGS_VH

// byte offsets
`define OFS_EXT_CTRL_LO     8'h66
`define OFS_EXT_CTRL_HI     8'h67
`define OFS_HCAP_OFS_LO     8'h68
`define OFS_HCAP_OFS_HI     8'h69
`define OFS_VCAP_OFS_LO     8'h6A
`define OFS_VCAP_OFS_HI     8'h6B
`define OFS_HSCALE_LO       8'h6C
`define OFS_HSCALE_HI       8'h6D
`define OFS_VSCALE_LO       8'h6E
`define OFS_VSCALE_HI       8'h6F
`define OFS_HPAN_LO         8'h70

// extended control low fields
`define BIT_ZOOM            0
`define BIT_GAIN            1
`define BIT_FREEZE          2
`define BIT_INTERLACE       5
`define MASK_EXT_CTRL_LO    8'h27
// extended control high fields
`define MASK_EXT_CTRL_HI    8'h07
`define PAT_INVALID         3'h0

// reset values
`define RST_EXT_CTRL_LO     8'h00
`define RST_EXT_CTRL_HI     8'h00
`define RST_WORD            16'h0000

// timing: limit computation finishes within this time
`define LIMIT_TIME_MS       25
`define CLK_PERIOD_NS       10
`define LIMIT_CYCLES        ((`LIMIT_TIME_MS * 1000000) / `CLK_PERIOD_NS)

`endif

/* split_word_reg.v */
// one signed 16-bit register written as a low/high byte pair
// assumes writes are single-cycle strobes on the device clock
`timescale 1ns/1ns
`include "capture_window_scale_regs.vh"
module split_word_reg
(
  ref_clk,
  rst,
  wr_lo,
  wr_hi,
  wr_data,
  load_clamp,
  clamp_value,
  value,
  written
);
  input             ref_clk;      // device clock
  input             rst;          // async reset
  input             wr_lo;        // host writes bits 7..0
  input             wr_hi;        // host writes bits 15..8
  input      [7:0]  wr_data;      // host byte
  input             load_clamp;   // controller writes back limit
  input      [15:0] clamp_value;  // clamped value
  output     [15:0] value;        // current contents
  output            written;      // pulse on any host byte write

  reg [15:0] value_q;             // stored word

  assign value   = value_q;
  assign written = wr_lo | wr_hi;

  // host byte writes win over a controller write-back in the same cycle
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      value_q <= `RST_WORD;
    else if (wr_lo | wr_hi)
    begin
      if (wr_lo)
        value_q[7:0] <= wr_data;
      if (wr_hi)
        value_q[15:8] <= wr_data;
    end
    else if (load_clamp)
      value_q <= clamp_value;
  end
endmodule // split_word_reg

/* limit_clamp.v */
// clamps one signed 16-bit value between a minimum and a maximum
// assumes limits are given as two's complement and min <= max
`timescale 1ns/1ns
module limit_clamp
(
  value,
  lim_min,
  lim_max,
  clamped,
  changed
);
  input      [15:0] value;    // value as written
  input      [15:0] lim_min;  // lower limit
  input      [15:0] lim_max;  // upper limit
  output reg [15:0] clamped;  // value inside the limits
  output            changed;  // clamping altered the value

  assign changed = (clamped != value);

  // signed compare against both limits
  always @*
  begin
    if ($signed(value) > $signed(lim_max))
      clamped = lim_max;
    else if ($signed(value) < $signed(lim_min))
      clamped = lim_min;
    else
      clamped = value;
  end
endmodule // limit_clamp

/* capture_window_scale_regs.v */
// register bank for capture window offset, scale steps, mode bits and test pattern
// the four signed words are clamped to controller limits once the limit timer runs out
// assumes a byte register port (addr, wr/rd strobes) from the serial slave, limits from the controller
// assumes the limit inputs are stable on the device clock and min <= max for every word
`timescale 1ns/1ns
`include "capture_window_scale_regs.vh"

// byte map served here
//   0x66       mode byte: zoom, input gain, freeze, interlace detect
//   0x67       test pattern code, three bits
//   0x68/0x69  horizontal capture offset, low then high byte
//   0x6A/0x6B  vertical capture offset, low then high byte
//   0x6C/0x6D  horizontal scale step, low then high byte
//   0x6E/0x6F  vertical scale step, low then high byte
//   0x70       horizontal pan position, low byte only
// every other address reads zero and ignores writes
// writes to 0x68..0x70 (re)start the limit timer; when it runs out
// all four words are replaced by their clamped values in one cycle

module capture_window_scale_regs
#(
  parameter LIMIT_CYCLES = `LIMIT_CYCLES  // worst-case limit computation time
)
(
  ref_clk,
  rst,
  reg_addr,
  reg_wr,
  reg_wdata,
  reg_rd,
  reg_rdata,
  hcap_min,
  hcap_max,
  vcap_min,
  vcap_max,
  hscale_min,
  hscale_max,
  vscale_min,
  vscale_max,
  output_calibration_bit,
  limits_busy,
  zoom_enable,
  input_gain_select,
  freeze_frame,
  interlace_detect_enable,
  test_pattern_select,
  test_pattern_active,
  hcap_shift,
  vcap_shift,
  hscale_adjust,
  vscale_adjust,
  horiz_pan_position_low,
  pan_low_active
);
  // register port
  input             ref_clk;                  // device clock
  input             rst;                      // async reset, active high
  input      [7:0]  reg_addr;                 // register byte address
  input             reg_wr;                   // write strobe
  input      [7:0]  reg_wdata;                // write byte
  input             reg_rd;                   // read strobe
  output reg [7:0]  reg_rdata;                // read byte, registered
  // limits from the controller, signed
  input      [15:0] hcap_min;                 // horizontal offset limits
  input      [15:0] hcap_max;
  input      [15:0] vcap_min;                 // vertical offset limits
  input      [15:0] vcap_max;
  input      [15:0] hscale_min;               // horizontal step limits
  input      [15:0] hscale_max;
  input      [15:0] vscale_min;               // vertical step limits
  input      [15:0] vscale_max;
  input             output_calibration_bit;   // from system control register
  // mode, pattern and pan outputs
  output            limits_busy;              // controller computing limits
  output            zoom_enable;              // zoom mode
  output            input_gain_select;        // 0: 1x, 1: 1.43x
  output            freeze_frame;             // 0: continuous, 1: frozen
  output            interlace_detect_enable;  // 1: detect interlaced input
  output     [2:0]  test_pattern_select;      // pattern code
  output            test_pattern_active;      // pattern drives output
  // effective signed values
  output reg [15:0] hcap_shift;               // signed horizontal window shift
  output reg [15:0] vcap_shift;               // signed vertical window shift
  output reg [15:0] hscale_adjust;            // signed horizontal step
  output reg [15:0] vscale_adjust;            // signed vertical step
  output     [7:0]  horiz_pan_position_low;   // pan low byte
  output            pan_low_active;           // pan byte in effect

  // limit controller states
  localparam ST_IDLE  = 1'b0;                 // no computation pending
  localparam ST_CALC  = 1'b1;                 // computing limits

  // byte registers and the limit timer
  reg  [7:0]  ext_ctrl_lo_q;                  // extended control low
  reg  [7:0]  ext_ctrl_hi_q;                  // extended control high
  reg  [7:0]  pan_lo_q;                       // pan position low byte
  reg         state_q;                        // limit controller state
  reg  [31:0] calc_cnt_q;                     // computation timer

  // per-word plumbing between decode, storage and clamps
  wire [3:0]  wr_lo;                          // per-word low byte writes
  wire [3:0]  wr_hi;                          // per-word high byte writes
  wire [3:0]  word_written;                   // per-word write pulses
  wire [63:0] words;                          // all four words packed
  wire [63:0] clamped;                        // clamped values packed
  wire [63:0] lim_min;                        // limits packed
  wire [63:0] lim_max;
  wire        calc_done;                      // write-back moment
  wire        any_written;                    // any limited register written

  // limits packed in word order: h offset, v offset, h step, v step
  assign lim_min = {vscale_min, hscale_min, vcap_min, hcap_min};
  assign lim_max = {vscale_max, hscale_max, vcap_max, hcap_max};

  // one word register and clamp per offset / step value
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_word
      // byte addresses of this word, kept 32 bits wide for the compare
      localparam [31:0] LO_ADDR = `OFS_HCAP_OFS_LO + 2 * gi;
      localparam [31:0] HI_ADDR = `OFS_HCAP_OFS_HI + 2 * gi;

      // low byte at even offset, high byte at next
      assign wr_lo[gi] = reg_wr & ({24'h000000, reg_addr} == LO_ADDR);
      assign wr_hi[gi] = reg_wr & ({24'h000000, reg_addr} == HI_ADDR);

      // storage: host bytes win over the write-back
      split_word_reg u_word
      (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .wr_lo       (wr_lo[gi]),
        .wr_hi       (wr_hi[gi]),
        .wr_data     (reg_wdata),
        .load_clamp  (calc_done),
        .clamp_value (clamped[gi*16 +: 16]),
        .value       (words[gi*16 +: 16]),
        .written     (word_written[gi])
      );

      // clamp against this word's limits, used only at write-back
      limit_clamp u_clamp
      (
        .value   (words[gi*16 +: 16]),
        .lim_min (lim_min[gi*16 +: 16]),
        .lim_max (lim_max[gi*16 +: 16]),
        .clamped (clamped[gi*16 +: 16]),
        .changed ()
      );
    end
  endgenerate

  // any write that must restart the limit computation
  assign any_written = (|word_written) | (reg_wr & (reg_addr == `OFS_HPAN_LO));

  // control bytes and pan byte, reserved bits dropped on write
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      // all modes off, pattern invalid
      ext_ctrl_lo_q <= `RST_EXT_CTRL_LO;
      ext_ctrl_hi_q <= `RST_EXT_CTRL_HI;
      pan_lo_q      <= 8'h00;
    end
    else if (reg_wr)
    begin
      // mode byte
      if (reg_addr == `OFS_EXT_CTRL_LO)
        ext_ctrl_lo_q <= reg_wdata & `MASK_EXT_CTRL_LO;
      // pattern byte
      if (reg_addr == `OFS_EXT_CTRL_HI)
        ext_ctrl_hi_q <= reg_wdata & `MASK_EXT_CTRL_HI;
      // pan byte, stored as written
      if (reg_addr == `OFS_HPAN_LO)
        pan_lo_q <= reg_wdata;
    end
  end

  // limit controller: each new write restarts the computation window
  // the count runs from 0 up to LIMIT_CYCLES - 1 while busy
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      // idle after reset, nothing to clamp
      state_q    <= ST_IDLE;
      calc_cnt_q <= 32'h00000000;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          // waiting for a limited register write
          if (any_written)
          begin
            state_q    <= ST_CALC;
            calc_cnt_q <= 32'h00000000;
          end
        end
        ST_CALC:
        begin
          // a fresh write pushes the deadline out again
          if (any_written)
            calc_cnt_q <= 32'h00000000;         // restart on new value
          else if (calc_done)
            state_q <= ST_IDLE;
          else
            calc_cnt_q <= calc_cnt_q + 32'h00000001;
        end
        // unreachable with a single state bit
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // write-back at the end of the computation window
  // a host write in the last cycle wins and restarts the timer,
  // so the write-back never fights a byte write in the word registers
  assign calc_done   = (state_q == ST_CALC) & ~any_written &
                       (calc_cnt_q == LIMIT_CYCLES - 1);
  // busy from the first write until the write-back edge
  assign limits_busy = (state_q == ST_CALC);

  // mode bits
  assign zoom_enable             = ext_ctrl_lo_q[`BIT_ZOOM];
  assign input_gain_select       = ext_ctrl_lo_q[`BIT_GAIN];
  assign freeze_frame            = ext_ctrl_lo_q[`BIT_FREEZE];
  assign interlace_detect_enable = ext_ctrl_lo_q[`BIT_INTERLACE];
  assign test_pattern_select     = ext_ctrl_hi_q[2:0];
  // pattern only drives the output with calibration on and a valid code
  assign test_pattern_active     = output_calibration_bit &
                                   (ext_ctrl_hi_q[2:0] != `PAT_INVALID);
  assign horiz_pan_position_low  = pan_lo_q;
  assign pan_low_active          = zoom_enable;

  // effective offsets and steps; offsets held at zero in zoom mode
  // one cycle lag behind the stored words is harmless for frame-rate users
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      // neutral shift and scale after reset
      hcap_shift    <= `RST_WORD;
      vcap_shift    <= `RST_WORD;
      hscale_adjust <= `RST_WORD;
      vscale_adjust <= `RST_WORD;
    end
    else
    begin
      // zoom hands positioning over to the pan registers
      hcap_shift    <= zoom_enable ? `RST_WORD : words[15:0];
      vcap_shift    <= zoom_enable ? `RST_WORD : words[31:16];
      hscale_adjust <= words[47:32];
      vscale_adjust <= words[63:48];
    end
  end

  // registered read port
  // outside a read strobe the last byte stands
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        // mode bytes
        `OFS_EXT_CTRL_LO: reg_rdata <= ext_ctrl_lo_q;
        `OFS_EXT_CTRL_HI: reg_rdata <= ext_ctrl_hi_q;
        // capture offsets
        `OFS_HCAP_OFS_LO: reg_rdata <= words[7:0];
        `OFS_HCAP_OFS_HI: reg_rdata <= words[15:8];
        `OFS_VCAP_OFS_LO: reg_rdata <= words[23:16];
        `OFS_VCAP_OFS_HI: reg_rdata <= words[31:24];
        // scale steps
        `OFS_HSCALE_LO:   reg_rdata <= words[39:32];
        `OFS_HSCALE_HI:   reg_rdata <= words[47:40];
        `OFS_VSCALE_LO:   reg_rdata <= words[55:48];
        `OFS_VSCALE_HI:   reg_rdata <= words[63:56];
        // pan low byte
        `OFS_HPAN_LO:     reg_rdata <= pan_lo_q;
        default:          reg_rdata <= 8'h00;          // unmapped reads zero
      endcase
    end
  end
endmodule // capture_window_scale_regs

/* capture_window_scale_regs_sva.sv */
// port assertions for the capture window / scale register bank
// assumes one clock domain, reset async active high
`timescale 1ns/1ns
module cws_checker
#(
  parameter int LIMIT_CYCLES = 16  // limit timer length
)
(
  input logic        ref_clk,
  input logic        rst,
  input logic [7:0]  reg_addr,
  input logic        reg_wr,
  input logic [7:0]  reg_wdata,
  input logic        reg_rd,
  input logic [7:0]  reg_rdata,
  input logic [15:0] hcap_min,
  input logic [15:0] hcap_max,
  input logic [15:0] hscale_min,
  input logic [15:0] hscale_max,
  input logic        output_calibration_bit,
  input logic        limits_busy,
  input logic        zoom_enable,
  input logic        input_gain_select,
  input logic        freeze_frame,
  input logic        interlace_detect_enable,
  input logic [2:0]  test_pattern_select,
  input logic        test_pattern_active,
  input logic [15:0] hcap_shift,
  input logic [15:0] vcap_shift,
  input logic [15:0] hscale_adjust,
  input logic        pan_low_active
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic        calc_wr;     // write that restarts the limit timer
  logic [31:0] busy_cnt_q;  // busy cycles since that write
  logic [7:0]  wdata_q;     // last cycle's write byte
  assign calc_wr = reg_wr && reg_addr >= 8'h68 && reg_addr <= 8'h70;
  // busy counter and write byte copy
  always @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      busy_cnt_q <= 32'h0;
      wdata_q    <= 8'h00;
    end
    else
    begin
      wdata_q    <= reg_wdata;
      busy_cnt_q <= calc_wr ? 32'h0 : busy_cnt_q + {31'h0, limits_busy};
    end
  property p_busy_start; calc_wr |=> limits_busy; endproperty
  a_busy_start: assert property (p_busy_start) else $error("timer not started");
  property p_busy_len; limits_busy |-> busy_cnt_q < LIMIT_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("limits late");
  property p_zoom_h; zoom_enable |=> hcap_shift == 16'h0000; endproperty
  a_zoom_h: assert property (p_zoom_h) else $error("h offset used in zoom");
  property p_zoom_v; zoom_enable |=> vcap_shift == 16'h0000; endproperty
  a_zoom_v: assert property (p_zoom_v) else $error("v offset used in zoom");
  property p_pan; reg_wr && reg_addr == 8'h66 |=> pan_low_active == wdata_q[0]; endproperty
  a_pan: assert property (p_pan) else $error("pan activity wrong");
  property p_pat_act;
    test_pattern_active == (output_calibration_bit && test_pattern_select != 3'h0);
  endproperty
  a_pat_act: assert property (p_pat_act) else $error("pattern activity wrong");
  property p_ctrl;
    reg_wr && reg_addr == 8'h66 |=> {interlace_detect_enable, freeze_frame, input_gain_select,
      zoom_enable} == {wdata_q[5], wdata_q[2:0]};
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("mode bits wrong");
  property p_pat; reg_wr && reg_addr == 8'h67 |=> test_pattern_select == wdata_q[2:0]; endproperty
  a_pat: assert property (p_pat) else $error("pattern code wrong");
  property p_rsv; reg_rd && reg_addr == 8'h66 |=> (reg_rdata & 8'hD8) == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_clamp_hs;
    $fell(limits_busy) |=> $signed(hscale_adjust) >= $signed(hscale_min) &&
      $signed(hscale_adjust) <= $signed(hscale_max);
  endproperty
  a_clamp_hs: assert property (p_clamp_hs) else $error("step not clamped");
  property p_clamp_hc;
    $fell(limits_busy) && !zoom_enable |=> $signed(hcap_shift) >= $signed(hcap_min) &&
      $signed(hcap_shift) <= $signed(hcap_max);
  endproperty
  a_clamp_hc: assert property (p_clamp_hc) else $error("offset not clamped");
  c_wb: cover property ($fell(limits_busy));
  c_zoom: cover property ($rose(zoom_enable));
  c_pat: cover property (test_pattern_active);
endmodule // cws_checker
bind capture_window_scale_regs cws_checker #(.LIMIT_CYCLES(LIMIT_CYCLES)) u_chk
(
  .ref_clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .hcap_min, .hcap_max,
  .hscale_min, .hscale_max, .output_calibration_bit, .limits_busy, .zoom_enable,
  .input_gain_select, .freeze_frame, .interlace_detect_enable, .test_pattern_select,
  .test_pattern_active, .hcap_shift, .vcap_shift, .hscale_adjust, .pan_low_active
);

/* capture_window_scale_regs_host.sv */
// host processor model on the byte register port
// assumes the device samples strobes on the rising edge
`timescale 1ns/1ns
module cws_host
(
  input  wire logic       ref_clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // idle bus at time zero
  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
  end
  // one byte write; released lines show the inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge ref_clk);
    {reg_addr, reg_wdata, reg_wr} <= {~a, ~d, 1'b0};
  endtask
  // one byte read; data taken the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge ref_clk);
    {reg_addr, reg_rd} <= {~a, 1'b0};
    #1 d = reg_rdata;
  endtask
endmodule // cws_host

/* test_capture_window_scale_regs.sv */
// self-checking bench for the capture window / scale register bank
// assumes the host model and the bound checker files
`timescale 1ns/1ns
module test_capture_window_scale_regs;
  localparam int LIM = 16;               // shortened limit time
  logic        ref_clk = 1'b0;           // device clock
  logic        rst = 1'b1;               // async reset
  logic        cal = 1'b0;               // output calibration bit
  logic [15:0] lim [0:7] = '{default: 16'h0000}; // min/max per word
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, pan_lo;
  logic        reg_wr, reg_rd, busy, zoom, gain, frz, intl, pat_act, pan_act;
  logic [2:0]  pat;
  logic [15:0] hsh, vsh, hsa, vsa;
  int          mismatches = 0;           // failed compares
  int          n_compared = 0;           // all compares
  int          cyc = 0;                  // timeout counter
  capture_window_scale_regs #(.LIMIT_CYCLES(LIM)) DUT
  (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hcap_min(lim[0]), .hcap_max(lim[1]),
    .vcap_min(lim[2]), .vcap_max(lim[3]), .hscale_min(lim[4]), .hscale_max(lim[5]),
    .vscale_min(lim[6]), .vscale_max(lim[7]), .output_calibration_bit(cal), .limits_busy(busy),
    .zoom_enable(zoom), .input_gain_select(gain), .freeze_frame(frz),
    .interlace_detect_enable(intl), .test_pattern_select(pat), .test_pattern_active(pat_act),
    .hcap_shift(hsh), .vcap_shift(vsh), .hscale_adjust(hsa), .vscale_adjust(vsa),
    .horiz_pan_position_low(pan_lo), .pan_low_active(pan_act)
  );
  cws_host host
  (
    .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );
  // 100 MHz clock
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  // one compare for every result
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // expected clamp of a written word
  function automatic logic [15:0] clampf(input logic [15:0] v, lo, hi);
    if ($signed(v) < $signed(lo)) return lo;
    if ($signed(v) > $signed(hi)) return hi;
    return v;
  endfunction
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // hang guard
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      $display("[FAIL] %0t timeout", $time);
      tally_and_finish;
    end
  end
  // main sequence
  initial
  begin
    int          seed;
    logic [7:0]  b, a;
    logic [15:0] v [0:3];
    logic [15:0] ex [0:3];
    logic [15:0] w, lo, hi;
    seed = 55;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 8'h66; i <= 8'h71; i++)
    begin
      host.rd(i[7:0], b);
      chk({8'h00, b}, 16'h0000, "reset value");
    end
    host.wr(8'h66, 8'hFF);
    host.rd(8'h66, b);
    chk({8'h00, b}, 16'h0027, "ctrl readback");
    chk({12'h000, intl, frz, gain, zoom}, 16'h000F, "mode bits");
    host.wr(8'h66, 8'hDA);
    host.rd(8'h66, b);
    chk({8'h00, b}, 16'h0002, "ctrl readback");
    chk({12'h000, intl, frz, gain, zoom}, 16'h0002, "mode bits");
    for (int p = 0; p < 8; p++)
    begin
      host.wr(8'h67, {5'h1F, p[2:0]});
      cal <= ~p[1];
      host.rd(8'h67, b);
      chk({8'h00, b}, {13'h0, p[2:0]}, "pattern code");
      chk({15'h0, pat_act}, {15'h0, !p[1] && p != 0}, "pattern on");
    end
    host.wr(8'h80, 8'hA5);
    host.rd(8'h80, b);
    chk({8'h00, b}, 16'h0000, "unmapped");
    for (int i = 0; i < 24; i++)
    begin
      for (int k = 0; k < 8; k += 2)
      begin
        lo = $random(seed);
        hi = $random(seed);
        if ($signed(lo) > $signed(hi))
          {lo, hi} = {hi, lo};
        lim[k] <= lo;
        lim[k+1] <= hi;
        v[k/2] = (i == 0) ? 16'h8000 : (i == 1) ? 16'h7FFF : $random(seed);
        a = 8'h68 + k[7:0];
        host.wr(a, v[k/2][7:0]);
        host.wr(a + 8'h01, v[k/2][15:8]);
      end
      host.wr(8'h66, {7'h00, i[0]});
      chk({15'h0, busy}, 16'h0001, "busy after write");
      repeat (LIM + 4) @(posedge ref_clk);
      chk({15'h0, busy}, 16'h0000, "busy after limit time");
      for (int k = 0; k < 8; k += 2)
      begin
        a = 8'h68 + k[7:0];
        host.rd(a, b);
        w[7:0] = b;
        host.rd(a + 8'h01, b);
        w[15:8] = b;
        ex[k/2] = clampf(v[k/2], lim[k], lim[k+1]);
        chk(w, ex[k/2], "word readback");
      end
      chk(hsa, ex[2], "h step");
      chk(vsa, ex[3], "v step");
      chk(hsh, i[0] ? 16'h0000 : ex[0], "h shift");
      chk(vsh, i[0] ? 16'h0000 : ex[1], "v shift");
      chk({15'h0, pan_act}, {15'h0, i[0]}, "pan active");
    end
    host.wr(8'h70, 8'h9C);
    repeat (LIM + 4) @(posedge ref_clk);
    host.rd(8'h70, b);
    chk({8'h00, b}, 16'h009C, "pan readback");
    chk({8'h00, pan_lo}, 16'h009C, "pan byte");
    tally_and_finish;
  end
endmodule // test_capture_window_scale_regs
